// file: common/tsr_regs.svh
// Purpose: Register map, field positions, reset values and prescale counts
//          of the timer block.
// Assumes: Avalon-MM byte addressing, one 32-bit word per register.
// Notes:   Byte address is four times the word index below.
//
// Overview of operation
// - Split mode low byte counts clock or pin.
// - Gate lets interrupt pin enable low byte.
// - Split high byte counts prescaled clock only.
// - High byte uses second run, sets second flag.
// - Second timer mode 3 halts second timer.
// - While split, second runs in modes 0-2.
// - Split second timer still feeds baud, readable.
// - Timers default to one step per 12.
// - Rate bits 3,4,5; 0 is /12, 1 is /4.
// - Rate ignored for pin counting, third baud.
// - Third timer is always a 16-bit counter.
// - Capture/reload bytes capture or supply reload value.
// - Third overflow flag set unless baud selected.
// - Trigger edge with enable sets external flag.
// - Software writing flag one raises request.
// - Clock selects pick third or second overflow.
// - Enabled trigger edges capture/reload, except baud.
// - Third run bit alone starts or holds.
// - Third source: pin, /4 or /12, baud /2.
// - Capture select picks capture or reload action.
// - Baud mode forces reload on every overflow.
// - Mode field: 13-bit, 16-bit, 8-bit reload, split.
// - Gate set needs pin high and run bit.
// - First/second flags clear on interrupt vectoring.
`ifndef TSR_REGS_SVH
`define TSR_REGS_SVH

`define TSR_AW 10

`define TSR_IDX_TCTL 8'h88
`define TSR_IDX_TMODE 8'h89
`define TSR_IDX_CNT0_LO 8'h8A
`define TSR_IDX_CNT1_LO 8'h8B
`define TSR_IDX_CNT0_HI 8'h8C
`define TSR_IDX_CNT1_HI 8'h8D
`define TSR_IDX_CKCTL 8'h8E
`define TSR_IDX_T2CTL 8'hC8
`define TSR_IDX_RCAPL 8'hCA
`define TSR_IDX_RCAPH 8'hCB
`define TSR_IDX_CNT2_LO 8'hCC
`define TSR_IDX_CNT2_HI 8'hCD

`define TSR_RST_CKCTL 8'h00
`define TSR_RST_T2CTL 8'h00
`define TSR_RST_BYTE 8'h00
`define TSR_TCTL_MASK 8'hF0

`define TSR_CK_RATE0 3
`define TSR_CK_RATE1 4
`define TSR_CK_RATE2 5

`define TSR_TM_MODE0 1:0
`define TSR_TM_CT0 2
`define TSR_TM_GATE0 3
`define TSR_TM_MODE1 5:4
`define TSR_TM_CT1 6
`define TSR_TM_GATE1 7

`define TSR_TC_RUN0 4
`define TSR_TC_FLAG0 5
`define TSR_TC_RUN1 6
`define TSR_TC_FLAG1 7

`define TSR_C2_CPRL 0
`define TSR_C2_CT 1
`define TSR_C2_RUN 2
`define TSR_C2_EXEN 3
`define TSR_C2_TXSEL 4
`define TSR_C2_RXSEL 5
`define TSR_C2_EXF 6
`define TSR_C2_TF 7

`define TSR_PRE_SLOW_LAST 4'hB
`define TSR_C2_TOP 16'hFFFF

`endif

// file: common/tsr_pkg.sv
// Purpose: Types shared by the timer block files.
// Assumes: tsr_regs.svh supplies the address width.
// Notes:   All state of a module lives in one packed struct.
`include "tsr_regs.svh"
package tsr_pkg;

	typedef enum logic [1:0] {TSR_M13, TSR_M16, TSR_M8R, TSR_MSPLIT} tsr_tmode_e;

	typedef struct packed {
		logic read;
		logic write;
		logic [`TSR_AW-1:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} tsr_avs_req_s;

	typedef struct packed {
		logic waitrequest;
		logic [31:0] readdata;
	} tsr_avs_rsp_s;

	typedef struct packed {
		logic first_count_pin;
		logic second_count_pin;
		logic third_count_pin;
		logic third_timer_trigger_pin;
		logic first_external_interrupt_pin;
		logic second_external_interrupt_pin;
	} tsr_pins_s;

	typedef struct packed {
		tsr_pins_s meta;
		tsr_pins_s stable;
		tsr_pins_s prev;
	} tsr_sync_s;

	typedef struct packed {
		logic first_timer_overflow_flag;
		logic second_timer_overflow_flag;
		logic third_timer_irq;
		logic second_timer_overflow_tick;
		logic rx_baud_tick;
		logic tx_baud_tick;
	} tsr_evt_s;

	typedef struct packed {
		logic [7:0] tctl;
		logic [7:0] tmode;
		logic [7:0] cnt0_lo;
		logic [7:0] cnt0_hi;
		logic [7:0] cnt1_lo;
		logic [7:0] cnt1_hi;
		logic [7:0] ckctl;
		logic [7:0] t2ctl;
		logic [7:0] rcap_l;
		logic [7:0] rcap_h;
		logic [7:0] cnt2_lo;
		logic [7:0] cnt2_hi;
		logic [3:0] div12;
		logic [1:0] div4;
		logic div2;
		logic wait_req;
		logic [31:0] rdata;
		tsr_evt_s evt;
	} tsr_state_s;

endpackage

// file: rtl/tsr_pin_sync.sv
// Purpose: Two-stage synchroniser and falling-edge detect for timer pins.
// Assumes: Pins are slow against core_clk.
// Notes:   Edge is a high sample followed by a low sample.
`timescale 1ns/1ps
module tsr_pin_sync (
	input wire logic core_clk,
	input wire logic rst_n,
	input tsr_pkg::tsr_pins_s pins,
	output tsr_pkg::tsr_pins_s level,
	output tsr_pkg::tsr_pins_s fall
);

	tsr_pkg::tsr_sync_s st;
	tsr_pkg::tsr_sync_s next_st;

	always_comb begin
		next_st = st;
		next_st.meta = pins;
		next_st.stable = st.meta;
		next_st.prev = st.stable;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level = st.stable;
	assign fall = tsr_pkg::tsr_pins_s'(st.prev & ~st.stable);

endmodule // tsr_pin_sync

// file: rtl/tsr_timers.sv
// Purpose: Three timer/counters with split mode, rate select and
//          third-timer capture, reload and baud generation.
// Assumes: core_clk is the core output clock; Avalon-MM slave access.
// Notes:   Every output comes from the state register.
`timescale 1ns/1ps
`include "tsr_regs.svh"
module tsr_timers (
	input wire logic core_clk,
	input wire logic rst_n,
	input tsr_pkg::tsr_avs_req_s avs_req,
	output tsr_pkg::tsr_avs_rsp_s avs_rsp,
	input tsr_pkg::tsr_pins_s pins,
	input wire logic [1:0] serial_mode,
	input wire logic third_timer_irq_enable,
	input wire logic first_timer_vector_ack,
	input wire logic second_timer_vector_ack,
	output tsr_pkg::tsr_evt_s evt
);

	tsr_pkg::tsr_state_s st;
	tsr_pkg::tsr_state_s next_st;
	tsr_pkg::tsr_pins_s lvl;
	tsr_pkg::tsr_pins_s fall;
	tsr_pkg::tsr_tmode_e mode0;
	tsr_pkg::tsr_tmode_e mode1;

	logic tick12;
	logic tick4;
	logic tick2;
	logic split;
	logic rate0;
	logic rate1;
	logic rate2;
	logic src0;
	logic src1;
	logic src2;
	logic en0;
	logic en1;
	logic inc0;
	logic inc0h;
	logic inc1;
	logic inc2;
	logic ovf0;
	logic ovf0h;
	logic ovf1;
	logic baud;
	logic wrap2;
	logic trig;
	logic trig_act;
	logic rld;
	logic cap;
	logic wen;
	logic rload;
	logic [16:0] step0;
	logic [16:0] step1;
	logic [8:0] lo0;
	logic [8:0] hi0;
	logic [15:0] cnt2;
	logic [15:0] cnt2_inc;

	// One count step of a first/second timer in modes 0 to 2
	function automatic logic [16:0] tsr_step(
		input tsr_pkg::tsr_tmode_e m,
		input logic [7:0] lo,
		input logic [7:0] hi
	);
		logic [16:0] r;
		r = {1'b0, hi, lo};
		unique case (m)
			tsr_pkg::TSR_M13: begin
				if (lo[4:0] == 5'h1F) begin
					r[7:0] = {lo[7:5], 5'h00};
					r[15:8] = hi + 8'h01;
					r[16] = (hi == 8'hFF);
				end else begin
					r[7:0] = {lo[7:5], lo[4:0] + 5'h01};
				end
			end
			tsr_pkg::TSR_M16: begin
				r = {1'b0, hi, lo} + 17'h00001;
			end
			tsr_pkg::TSR_M8R: begin
				if (lo == 8'hFF) begin
					r[7:0] = hi;
					r[16] = 1'b1;
				end else begin
					r[7:0] = lo + 8'h01;
				end
			end
			tsr_pkg::TSR_MSPLIT: begin
				r = {1'b0, hi, lo};
			end
		endcase
		return r;
	endfunction

	// Word-aligned address match for one register index
	function automatic logic tsr_hit(
		input logic [`TSR_AW-1:0] a,
		input logic [7:0] idx
	);
		return a == {idx, 2'b00};
	endfunction

	// Register readback; unmapped words read as zero
	function automatic logic [7:0] tsr_rd(
		input tsr_pkg::tsr_state_s s,
		input logic [`TSR_AW-1:0] a
	);
		logic [7:0] d;
		d = 8'h00;
		if (tsr_hit(a, `TSR_IDX_TCTL)) d = s.tctl & `TSR_TCTL_MASK;
		if (tsr_hit(a, `TSR_IDX_TMODE)) d = s.tmode;
		if (tsr_hit(a, `TSR_IDX_CNT0_LO)) d = s.cnt0_lo;
		if (tsr_hit(a, `TSR_IDX_CNT1_LO)) d = s.cnt1_lo;
		if (tsr_hit(a, `TSR_IDX_CNT0_HI)) d = s.cnt0_hi;
		if (tsr_hit(a, `TSR_IDX_CNT1_HI)) d = s.cnt1_hi;
		if (tsr_hit(a, `TSR_IDX_CKCTL)) d = s.ckctl;
		if (tsr_hit(a, `TSR_IDX_T2CTL)) d = s.t2ctl;
		if (tsr_hit(a, `TSR_IDX_RCAPL)) d = s.rcap_l;
		if (tsr_hit(a, `TSR_IDX_RCAPH)) d = s.rcap_h;
		if (tsr_hit(a, `TSR_IDX_CNT2_LO)) d = s.cnt2_lo;
		if (tsr_hit(a, `TSR_IDX_CNT2_HI)) d = s.cnt2_hi;
		return d;
	endfunction

	tsr_pin_sync u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pins(pins),
		.level(lvl),
		.fall(fall)
	);

	// Shared prescaler taps
	assign tick12 = st.div12 == `TSR_PRE_SLOW_LAST;
	assign tick4 = st.div4 == 2'h3;
	assign tick2 = st.div2;

	assign mode0 = tsr_pkg::tsr_tmode_e'(st.tmode[`TSR_TM_MODE0]);
	assign mode1 = tsr_pkg::tsr_tmode_e'(st.tmode[`TSR_TM_MODE1]);
	assign split = mode0 == tsr_pkg::TSR_MSPLIT;

	// First timer
	assign rate0 = st.ckctl[`TSR_CK_RATE0] ? tick4 : tick12;
	assign src0 = st.tmode[`TSR_TM_CT0] ? fall.first_count_pin : rate0;
	assign en0 = st.tctl[`TSR_TC_RUN0]
		& (~st.tmode[`TSR_TM_GATE0] | lvl.first_external_interrupt_pin);
	assign inc0 = en0 & src0;
	assign inc0h = split & st.tctl[`TSR_TC_RUN1] & rate0;
	assign step0 = tsr_step(mode0, st.cnt0_lo, st.cnt0_hi);
	assign lo0 = {1'b0, st.cnt0_lo} + 9'h001;
	assign hi0 = {1'b0, st.cnt0_hi} + 9'h001;
	assign ovf0 = inc0 & (split ? lo0[8] : step0[16]);
	assign ovf0h = inc0h & hi0[8];

	// Second timer; run bit belongs to the high byte while split
	assign rate1 = st.ckctl[`TSR_CK_RATE1] ? tick4 : tick12;
	assign src1 = st.tmode[`TSR_TM_CT1] ? fall.second_count_pin : rate1;
	assign en1 = (split | st.tctl[`TSR_TC_RUN1])
		& (~st.tmode[`TSR_TM_GATE1] | lvl.second_external_interrupt_pin);
	assign inc1 = (mode1 != tsr_pkg::TSR_MSPLIT) & en1 & src1;
	assign step1 = tsr_step(mode1, st.cnt1_lo, st.cnt1_hi);
	assign ovf1 = inc1 & step1[16];

	// Third timer
	assign baud = st.t2ctl[`TSR_C2_RXSEL] | st.t2ctl[`TSR_C2_TXSEL];
	assign rate2 = baud ? tick2 : (st.ckctl[`TSR_CK_RATE2] ? tick4 : tick12);
	assign src2 = st.t2ctl[`TSR_C2_CT] ? fall.third_count_pin : rate2;
	assign inc2 = st.t2ctl[`TSR_C2_RUN] & src2;
	assign cnt2 = {st.cnt2_hi, st.cnt2_lo};
	assign cnt2_inc = cnt2 + 16'h0001;
	assign wrap2 = inc2 & (cnt2 == `TSR_C2_TOP);
	assign trig = st.t2ctl[`TSR_C2_EXEN] & fall.third_timer_trigger_pin;
	assign trig_act = trig & ~baud;
	assign rload = baud | ~st.t2ctl[`TSR_C2_CPRL];
	assign rld = (wrap2 & rload) | (trig_act & ~st.t2ctl[`TSR_C2_CPRL]);
	assign cap = trig_act & st.t2ctl[`TSR_C2_CPRL];

	// Write takes effect at the edge where waitrequest is seen low
	assign wen = avs_req.write & ~st.wait_req & avs_req.byteenable[0];

	always_comb begin
		next_st = st;

		next_st.div12 = tick12 ? 4'h0 : st.div12 + 4'h1;
		next_st.div4 = st.div4 + 2'h1;
		next_st.div2 = ~st.div2;

		if (split) begin
			if (inc0) begin
				next_st.cnt0_lo = lo0[7:0];
			end
			if (inc0h) begin
				next_st.cnt0_hi = hi0[7:0];
			end
		end else if (inc0) begin
			next_st.cnt0_lo = step0[7:0];
			next_st.cnt0_hi = step0[15:8];
		end

		if (inc1) begin
			next_st.cnt1_lo = step1[7:0];
			next_st.cnt1_hi = step1[15:8];
		end

		// Reload wins over a plain step in the same cycle
		if (rld) begin
			next_st.cnt2_lo = st.rcap_l;
			next_st.cnt2_hi = st.rcap_h;
		end else if (inc2) begin
			next_st.cnt2_lo = cnt2_inc[7:0];
			next_st.cnt2_hi = cnt2_inc[15:8];
		end
		if (cap) begin
			next_st.rcap_l = st.cnt2_lo;
			next_st.rcap_h = st.cnt2_hi;
		end

		// Vectoring clears the first and second flags
		if (first_timer_vector_ack) begin
			next_st.tctl[`TSR_TC_FLAG0] = 1'b0;
		end
		if (second_timer_vector_ack) begin
			next_st.tctl[`TSR_TC_FLAG1] = 1'b0;
		end

		// Software writes override counter, capture and vectoring updates of the same byte
		if (wen) begin
			if (tsr_hit(avs_req.address, `TSR_IDX_TCTL)) begin
				next_st.tctl = avs_req.writedata[7:0] & `TSR_TCTL_MASK;
			end
			if (tsr_hit(avs_req.address, `TSR_IDX_TMODE)) begin
				next_st.tmode = avs_req.writedata[7:0];
			end
			if (tsr_hit(avs_req.address, `TSR_IDX_CNT0_LO)) begin
				next_st.cnt0_lo = avs_req.writedata[7:0];
			end
			if (tsr_hit(avs_req.address, `TSR_IDX_CNT1_LO)) begin
				next_st.cnt1_lo = avs_req.writedata[7:0];
			end
			if (tsr_hit(avs_req.address, `TSR_IDX_CNT0_HI)) begin
				next_st.cnt0_hi = avs_req.writedata[7:0];
			end
			if (tsr_hit(avs_req.address, `TSR_IDX_CNT1_HI)) begin
				next_st.cnt1_hi = avs_req.writedata[7:0];
			end
			if (tsr_hit(avs_req.address, `TSR_IDX_CKCTL)) begin
				next_st.ckctl = avs_req.writedata[7:0];
			end
			if (tsr_hit(avs_req.address, `TSR_IDX_T2CTL)) begin
				next_st.t2ctl = avs_req.writedata[7:0];
			end
			if (tsr_hit(avs_req.address, `TSR_IDX_RCAPL)) begin
				next_st.rcap_l = avs_req.writedata[7:0];
			end
			if (tsr_hit(avs_req.address, `TSR_IDX_RCAPH)) begin
				next_st.rcap_h = avs_req.writedata[7:0];
			end
			if (tsr_hit(avs_req.address, `TSR_IDX_CNT2_LO)) begin
				next_st.cnt2_lo = avs_req.writedata[7:0];
			end
			if (tsr_hit(avs_req.address, `TSR_IDX_CNT2_HI)) begin
				next_st.cnt2_hi = avs_req.writedata[7:0];
			end
		end

		// Hardware sets win over any clear in the same cycle
		next_st.tctl[`TSR_TC_FLAG0] = next_st.tctl[`TSR_TC_FLAG0] | ovf0;
		next_st.tctl[`TSR_TC_FLAG1] = next_st.tctl[`TSR_TC_FLAG1]
			| (split ? ovf0h : ovf1);
		next_st.t2ctl[`TSR_C2_TF] = next_st.t2ctl[`TSR_C2_TF] | (wrap2 & ~baud);
		next_st.t2ctl[`TSR_C2_EXF] = next_st.t2ctl[`TSR_C2_EXF] | trig;

		// Bus handshake: one wait cycle, then completion
		next_st.wait_req = ~((avs_req.read | avs_req.write) & st.wait_req);
		if (avs_req.read & st.wait_req) begin
			next_st.rdata = {24'h000000, tsr_rd(st, avs_req.address)};
		end

		// Registered event outputs
		next_st.evt.first_timer_overflow_flag = next_st.tctl[`TSR_TC_FLAG0];
		next_st.evt.second_timer_overflow_flag = next_st.tctl[`TSR_TC_FLAG1];
		next_st.evt.third_timer_irq = third_timer_irq_enable
			& (next_st.t2ctl[`TSR_C2_TF] | next_st.t2ctl[`TSR_C2_EXF]);
		next_st.evt.second_timer_overflow_tick = ovf1;
		next_st.evt.rx_baud_tick = serial_mode[0]
			& (st.t2ctl[`TSR_C2_RXSEL] ? wrap2 : ovf1);
		next_st.evt.tx_baud_tick = serial_mode[0]
			& (st.t2ctl[`TSR_C2_TXSEL] ? wrap2 : ovf1);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.ckctl <= `TSR_RST_CKCTL;
			st.t2ctl <= `TSR_RST_T2CTL;
			st.tmode <= `TSR_RST_BYTE;
			st.tctl <= `TSR_RST_BYTE;
			st.wait_req <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign avs_rsp.waitrequest = st.wait_req;
	assign avs_rsp.readdata = st.rdata;
	assign evt = st.evt;

endmodule // tsr_timers

// file: test/tsr_timers_monitor.sv
// Purpose: Port checks for the timer block.
// Assumes: Bound into every tsr_timers instance.
// Notes: Watches design ports only, inputs and outputs.
`timescale 1ns/1ps
module tsr_timers_monitor (
	input wire logic core_clk,
	input wire logic rst_n,
	input tsr_pkg::tsr_avs_req_s avs_req,
	input tsr_pkg::tsr_avs_rsp_s avs_rsp,
	input wire logic [1:0] serial_mode,
	input wire logic third_timer_irq_enable,
	input wire logic first_timer_vector_ack,
	input wire logic second_timer_vector_ack,
	input tsr_pkg::tsr_evt_s evt
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_bus_answer: assert property ((avs_req.read || avs_req.write) && avs_rsp.waitrequest
		|=> !avs_rsp.waitrequest) else $error("bus answer late");
	a_wait_short: assert property (!avs_rsp.waitrequest |=> avs_rsp.waitrequest)
		else $error("waitrequest low too long");
	a_irq_gated: assert property (
		!third_timer_irq_enable |=> !evt.third_timer_irq) else $error("irq while disabled");
	a_irq_hold: assert property (
		evt.third_timer_irq && third_timer_irq_enable && !avs_req.write |=> evt.third_timer_irq)
		else $error("third flag cleared by hardware");
	a_flag0_ack: assert property (
		first_timer_vector_ack |=> !evt.first_timer_overflow_flag) else $error("first flag kept");
	a_flag1_ack: assert property (
		second_timer_vector_ack |=> !evt.second_timer_overflow_flag) else $error("second flag kept");
	a_flag0_hold: assert property (
		evt.first_timer_overflow_flag && !first_timer_vector_ack && !avs_req.write
		|=> evt.first_timer_overflow_flag) else $error("first flag lost");
	a_baud_off: assert property (
		!serial_mode[0] [*2] |-> !evt.tx_baud_tick && !evt.rx_baud_tick)
		else $error("baud tick in serial mode 0 or 2");
endmodule // tsr_timers_monitor

bind tsr_timers tsr_timers_monitor u_mon (.core_clk, .rst_n, .avs_req, .avs_rsp, .serial_mode,
	.third_timer_irq_enable, .first_timer_vector_ack, .second_timer_vector_ack, .evt);

// file: test/tsr_far_model.sv
// Purpose: Far side: count, trigger and gate pins, serial port baud taps.
// Assumes: Count and trigger pins idle high, as with pull-ups; gate pins follow gate_high.
// Notes: Each edge is four cycles high then four low, slow against the synchroniser.
`timescale 1ns/1ps
module tsr_far_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic [3:0] mask,
	input wire logic [7:0] n_edges,
	input wire logic gate_high,
	input tsr_pkg::tsr_evt_s evt,
	output tsr_pkg::tsr_pins_s pins,
	output logic busy,
	output logic [15:0] rx_ticks
);
	logic [7:0] left;
	logic [2:0] ph;
	assign busy = left != 8'h00;
	assign pins = {~(mask & {4{busy & ph[2]}}), gate_high, gate_high};
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			left <= 8'h00;
			ph <= 3'h0;
			rx_ticks <= 16'h0000;
		end else begin
			ph <= go ? 3'h0 : ph + 3'h1;
			if (go) begin
				left <= n_edges;
			end else if (busy && ph == 3'h7) begin
				left <= left - 8'h01;
			end
			rx_ticks <= rx_ticks + {15'h0000, evt.rx_baud_tick};
		end
	end
endmodule // tsr_far_model

// file: test/tsr_timers_tb_top.sv
// Purpose: Self-checking bench for the timer block.
// Assumes: Register bus answers within 50 cycles.
// Notes: Plain register cases are table rows; timing cases follow.
`timescale 1ns/1ps
module tsr_timers_tb_top;
	logic core_clk;
	logic rst_n;
	tsr_pkg::tsr_avs_req_s req;
	tsr_pkg::tsr_avs_rsp_s rsp;
	tsr_pkg::tsr_pins_s pins;
	tsr_pkg::tsr_evt_s evt;
	logic [1:0] serial_mode;
	logic irq_en, ack0, ack1, go, gate_high, busy;
	logic [3:0] mask;
	logic [7:0] n_edges, v, e;
	logic [15:0] rx_ticks, d;
	int errors, total_checks, n, t;
	logic [23:0] rows [8] = '{24'h8E3838, 24'hCA5A5A, 24'hCBA5A5, 24'hCC1111,
		24'hCD2222, 24'hC80B0B, 24'h880F00, 24'h905500};
	logic [7:0] ctl_i [3] = '{8'h88, 8'h88, 8'hC8};
	logic [7:0] cnt_i [3] = '{8'h8A, 8'h8B, 8'hCC};
	logic [7:0] run_v [3] = '{8'h10, 8'h40, 8'h04};
	always #25 core_clk = ~core_clk;
	tsr_timers dut (.core_clk(core_clk), .rst_n(rst_n), .avs_req(req), .avs_rsp(rsp),
		.pins(pins), .serial_mode(serial_mode), .third_timer_irq_enable(irq_en),
		.first_timer_vector_ack(ack0), .second_timer_vector_ack(ack1), .evt(evt));
	tsr_far_model far (.core_clk(core_clk), .rst_n(rst_n), .go(go), .mask(mask),
		.n_edges(n_edges), .gate_high(gate_high), .evt(evt), .pins(pins), .busy(busy),
		.rx_ticks(rx_ticks));
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic limit();
		if (n == 400) begin
			errors++;
			wrap_up();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] wd);
		int k;
		k = 0;
		req.read <= !w;
		req.write <= w;
		req.address <= {i, 2'b00};
		req.writedata <= {24'h000000, wd};
		do begin
			@(posedge core_clk);
			k++;
		end while (rsp.waitrequest !== 1'b0 && k < 50);
		if (rsp.waitrequest !== 1'b0) begin
			errors++;
			wrap_up();
		end
		v = rsp.readdata[7:0];
		req.read <= 1'b0;
		req.write <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] wd);
		bus(1'b1, i, wd);
	endtask
	task automatic rc(input logic [7:0] i, input logic [7:0] exp);
		bus(1'b0, i, 8'h00);
		check(v, exp);
	endtask
	task automatic pulse(input logic [3:0] m, input logic [7:0] k);
		mask <= m;
		n_edges <= k;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		@(posedge core_clk);
		for (n = 0; n < 400 && busy !== 1'b0; n++) begin
			@(posedge core_clk);
		end
		limit();
		repeat (6) @(posedge core_clk);
	endtask
	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		req = '0;
		req.byteenable = 4'h1;
		serial_mode = 2'b00;
		irq_en = 1'b0;
		ack0 = 1'b0;
		ack1 = 1'b0;
		go = 1'b0;
		mask = 4'h0;
		n_edges = 8'h00;
		gate_high = 1'b0;
		errors = 0;
		total_checks = 0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		for (int r = 0; r < 8; r++) begin
			wr(rows[r][23:16], rows[r][15:8]);
			rc(rows[r][23:16], rows[r][7:0]);
		end
		// Second reset in mid-run: registers and events back to zero, waitrequest high
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		check({rsp.waitrequest, evt}, 7'h40);
		rst_n <= 1'b1;
		@(posedge core_clk);
		for (int r = 0; r < 8; r++) begin
			rc(rows[r][23:16], 8'h00);
		end
		// Each timer runs for a 240-cycle window at /12 then /4
		wr(8'h89, 8'h11);
		for (int k = 0; k < 6; k++) begin
			t = k % 3;
			wr(8'h8E, (k >= 3) ? (8'h08 << t) : 8'h00);
			wr(cnt_i[t], 8'h00);
			wr(ctl_i[t], run_v[t]);
			repeat (237) @(posedge core_clk);
			wr(ctl_i[t], 8'h00);
			bus(1'b0, cnt_i[t], 8'h00);
			e = (k >= 3) ? 8'd60 : 8'd20;
			check((v + 8'd1 >= e && v <= e + 8'd1) ? e : v, e);
		end
		wr(8'h8E, 8'h38);
		wr(8'h89, 8'h0F);
		wr(8'h8A, 8'h00);
		wr(8'hCC, 8'h00);
		wr(8'h88, 8'h10);
		wr(8'hC8, 8'h06);
		pulse(4'hA, 8'd5);
		rc(8'h8A, 8'h00);
		gate_high <= 1'b1;
		pulse(4'hA, 8'd5);
		rc(8'h8A, 8'h05);
		rc(8'hCC, 8'h0A);
		// Split: both halves of the first timer overflow quickly
		wr(8'hC8, 8'h00);
		wr(8'h88, 8'h00);
		wr(8'h89, 8'h23);
		wr(8'h8A, 8'hFF);
		wr(8'h8C, 8'hFF);
		wr(8'h8D, 8'hFE);
		wr(8'h8B, 8'hFF);
		wr(8'h88, 8'h50);
		repeat (40) @(posedge core_clk);
		check({evt.first_timer_overflow_flag, evt.second_timer_overflow_flag}, 2'h3);
		for (n = 0; n < 400 && evt.second_timer_overflow_tick !== 1'b1; n++) begin
			@(posedge core_clk);
		end
		limit();
		check(evt.second_timer_overflow_tick, 1'b1);
		wr(8'h88, 8'hA0);
		ack0 <= 1'b1;
		ack1 <= 1'b1;
		@(posedge core_clk);
		ack0 <= 1'b0;
		ack1 <= 1'b0;
		@(posedge core_clk);
		check({evt.first_timer_overflow_flag, evt.second_timer_overflow_flag}, 2'h0);
		wr(8'h89, 8'h30);
		wr(8'h88, 8'h40);
		bus(1'b0, 8'h8B, 8'h00);
		e = v;
		repeat (20) @(posedge core_clk);
		rc(8'h8B, e);
		// Third timer wraps from all ones and reloads
		irq_en <= 1'b1;
		wr(8'hCA, 8'h34);
		wr(8'hCB, 8'h12);
		wr(8'hCC, 8'hFF);
		wr(8'hCD, 8'hFF);
		wr(8'hC8, 8'h04);
		for (n = 0; n < 400 && evt.third_timer_irq !== 1'b1; n++) begin
			@(posedge core_clk);
		end
		limit();
		rc(8'hC8, 8'h84);
		wr(8'hC8, 8'h80);
		rc(8'hCD, 8'h12);
		wr(8'hC8, 8'h00);
		@(posedge core_clk);
		check(evt.third_timer_irq, 1'b0);
		wr(8'hC8, 8'h40);
		@(posedge core_clk);
		check(evt.third_timer_irq, 1'b1);
		irq_en <= 1'b0;
		repeat (2) @(posedge core_clk);
		check(evt.third_timer_irq, 1'b0);
		wr(8'hC8, 8'h09);
		wr(8'hCC, 8'h5A);
		wr(8'hCD, 8'hA5);
		pulse(4'h1, 8'd1);
		rc(8'hCA, 8'h5A);
		rc(8'hCB, 8'hA5);
		rc(8'hC8, 8'h49);
		// Baud mode: /2 time base, forced reload, no overflow flag
		wr(8'hC8, 8'h00);
		wr(8'hCA, 8'hF0);
		wr(8'hCB, 8'hFF);
		wr(8'hCC, 8'hF0);
		wr(8'hCD, 8'hFF);
		serial_mode <= 2'b01;
		d = rx_ticks;
		wr(8'hC8, 8'h35);
		repeat (200) @(posedge core_clk);
		rc(8'hC8, 8'h35);
		rc(8'hCD, 8'hFF);
		d = rx_ticks - d;
		check((d >= 16'd5 && d <= 16'd7) ? 16'd6 : d, 16'd6);
		wrap_up();
	end
endmodule // tsr_timers_tb_top
